// ===== core/wrc_context.v
// workspace register context: register access and context switch sequencing
`include "wrc_defs.vh"
module wrc_context (
    input  wire        clk,
    input  wire        rstn,
    // register access request
    input  wire        reg_req,
    input  wire        reg_we,
    input  wire        reg_byte,
    input  wire        reg_odd,
    input  wire [3:0]  reg_num,
    input  wire [15:0] reg_wdata,
    output wire        reg_busy,
    output reg         reg_done_r,
    output reg  [15:0] reg_rdata_r,
    // instruction fetch
    input  wire        fetch_req,
    output reg         fetch_done_r,
    output reg  [15:0] fetch_data_r,
    // context switch
    input  wire        ctx_req,
    input  wire [15:0] ctx_new_base,
    input  wire [15:0] ctx_new_pc,
    input  wire [15:0] ctx_new_psw,
    output reg         ctx_done_r,
    // program state
    input  wire        pc_load,
    input  wire [15:0] pc_load_val,
    input  wire        psw_load,
    input  wire [15:0] psw_load_val,
    output reg  [15:0] base_ptr_r,
    output reg  [15:0] pc_r,
    output reg  [15:0] processor_status_word_r,
    // external word memory
    output reg         mem_req_r,
    output reg         mem_we_r,
    output reg  [14:0] mem_waddr_r,
    output reg  [15:0] mem_wdata_r,
    input  wire        mem_ack,
    input  wire [15:0] mem_rdata
);
    // =========================================================
    // states
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_RD    = 3'h1;
    localparam [2:0] S_RMW   = 3'h2;
    localparam [2:0] S_WR    = 3'h3;
    localparam [2:0] S_FETCH = 3'h4;
    localparam [2:0] S_SAVE  = 3'h5;

    reg [2:0]  state_r;
    reg [1:0]  save_idx_r;
    reg        lat_byte_r;
    reg        lat_odd_r;
    reg [7:0]  lat_byte_data_r;
    reg [15:0] old_base_r;
    reg [15:0] old_pc_r;
    reg [15:0] old_psw_r;
    reg [15:0] new_pc_r;
    reg [15:0] new_psw_r;

    // =========================================================
    // address forming: byte address to word address
    function [14:0] word_of;
        input [15:0] base;
        input [3:0]  num;
        reg   [15:0] byte_addr;
        begin
            // each register is one word, two bytes on
            byte_addr = base + {11'h000, num, 1'b0};
            word_of   = byte_addr[15:1];
        end
    endfunction

    wire [7:0]  lane_byte;
    wire [15:0] lane_merged;
    wrc_byte_lane u_lane (
        .word_in     (mem_rdata),
        .odd_sel     (lat_odd_r),
        .byte_in     (lat_byte_data_r),
        .byte_out    (lane_byte),
        .word_merged (lane_merged)
    );

    assign reg_busy = (state_r != S_IDLE);

    // =========================================================
    // sequencer
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r                 <= S_IDLE;
            save_idx_r              <= 2'h0;
            lat_byte_r              <= 1'b0;
            lat_odd_r               <= 1'b0;
            lat_byte_data_r         <= 8'h00;
            old_base_r              <= 16'h0000;
            old_pc_r                <= 16'h0000;
            old_psw_r               <= 16'h0000;
            new_pc_r                <= 16'h0000;
            new_psw_r               <= 16'h0000;
            reg_done_r              <= 1'b0;
            reg_rdata_r             <= 16'h0000;
            fetch_done_r            <= 1'b0;
            fetch_data_r            <= 16'h0000;
            ctx_done_r              <= 1'b0;
            base_ptr_r              <= `WRC_BASE_RST;
            pc_r                    <= `WRC_PC_RST;
            processor_status_word_r <= `WRC_PSW_RST;
            mem_req_r               <= 1'b0;
            mem_we_r                <= 1'b0;
            mem_waddr_r             <= 15'h0000;
            mem_wdata_r             <= 16'h0000;
        end else begin
            reg_done_r   <= 1'b0;
            fetch_done_r <= 1'b0;
            ctx_done_r   <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (pc_load)
                        pc_r <= pc_load_val;
                    if (psw_load)
                        processor_status_word_r <= psw_load_val;
                    // context switch has priority over register traffic
                    if (ctx_req) begin
                        old_base_r <= base_ptr_r;
                        old_pc_r   <= pc_r;
                        old_psw_r  <= processor_status_word_r;
                        new_pc_r   <= ctx_new_pc;
                        new_psw_r  <= ctx_new_psw;
                        base_ptr_r <= ctx_new_base;
                        mem_req_r  <= 1'b1;
                        mem_we_r   <= 1'b1;
                        mem_waddr_r <= word_of(ctx_new_base, `WRC_REG_OLD_BASE);
                        mem_wdata_r <= base_ptr_r;
                        save_idx_r <= 2'h0;
                        state_r    <= S_SAVE;
                    end else if (reg_req) begin
                        lat_byte_r      <= reg_byte;
                        lat_odd_r       <= reg_odd;
                        lat_byte_data_r <= reg_wdata[7:0];
                        mem_req_r       <= 1'b1;
                        mem_waddr_r     <= word_of(base_ptr_r, reg_num);
                        mem_wdata_r     <= reg_wdata;
                        // byte write needs the other half of the word first
                        if (reg_we && !reg_byte) begin
                            mem_we_r <= 1'b1;
                            state_r  <= S_WR;
                        end else begin
                            mem_we_r <= 1'b0;
                            state_r  <= reg_we ? S_RMW : S_RD;
                        end
                    end else if (fetch_req) begin
                        mem_req_r   <= 1'b1;
                        mem_we_r    <= 1'b0;
                        mem_waddr_r <= pc_r[15:1];
                        state_r     <= S_FETCH;
                    end
                end
                S_RD: begin
                    if (mem_ack) begin
                        mem_req_r   <= 1'b0;
                        reg_done_r  <= 1'b1;
                        reg_rdata_r <= lat_byte_r ? {lane_byte, 8'h00} : mem_rdata;
                        state_r     <= S_IDLE;
                    end
                end
                S_RMW: begin
                    if (mem_ack) begin
                        mem_we_r    <= 1'b1;
                        mem_wdata_r <= lane_merged;
                        state_r     <= S_WR;
                    end
                end
                S_WR: begin
                    if (mem_ack) begin
                        mem_req_r  <= 1'b0;
                        mem_we_r   <= 1'b0;
                        reg_done_r <= 1'b1;
                        state_r    <= S_IDLE;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        mem_req_r    <= 1'b0;
                        fetch_done_r <= 1'b1;
                        fetch_data_r <= mem_rdata;
                        pc_r         <= pc_r + `WRC_PC_STEP;
                        state_r      <= S_IDLE;
                    end
                end
                S_SAVE: begin
                    if (mem_ack) begin
                        save_idx_r <= save_idx_r + 2'h1;
                        case (save_idx_r)
                            2'h0: begin
                                mem_waddr_r <= word_of(base_ptr_r, `WRC_REG_OLD_PC);
                                mem_wdata_r <= old_pc_r;
                            end
                            2'h1: begin
                                mem_waddr_r <= word_of(base_ptr_r, `WRC_REG_OLD_PSW);
                                mem_wdata_r <= old_psw_r;
                            end
                            default: begin
                                // three stores done; new context takes over
                                mem_req_r               <= 1'b0;
                                mem_we_r                <= 1'b0;
                                pc_r                    <= new_pc_r;
                                processor_status_word_r <= new_psw_r;
                                ctx_done_r              <= 1'b1;
                                state_r                 <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    mem_req_r <= 1'b0;
                    state_r   <= S_IDLE;
                end
            endcase
        end
    end
endmodule // wrc_context

// ===== include/wrc_defs.vh
// constants for the workspace register context block
`ifndef WRC_DEFS_VH
`define WRC_DEFS_VH
`define WRC_WORD_W       16
`define WRC_BYTE_W       8
`define WRC_WADDR_W      15
`define WRC_NUM_REGS     16
`define WRC_REG_OLD_BASE 4'hd
`define WRC_REG_OLD_PC   4'he
`define WRC_REG_OLD_PSW  4'hf
`define WRC_BASE_RST     16'h0000
`define WRC_PC_RST       16'h0000
`define WRC_PSW_RST      16'h0000
`define WRC_PC_STEP      16'h0002
`endif

// ===== core/wrc_byte_lane.v
// byte lane select and merge within a 16-bit memory word
`include "wrc_defs.vh"
module wrc_byte_lane (
    input  wire [15:0] word_in,
    input  wire        odd_sel,
    input  wire [7:0]  byte_in,
    output wire [7:0]  byte_out,
    output wire [15:0] word_merged
);
    // even byte sits in the high half, odd byte in the low half
    assign byte_out    = odd_sel ? word_in[7:0] : word_in[15:8];
    assign word_merged = odd_sel ? {word_in[15:8], byte_in}
                                 : {byte_in, word_in[7:0]};
endmodule // wrc_byte_lane

// ===== tb/wrc_checker.sv
// assertions on the ports of the workspace register context block
module wrc_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        reg_req,
    input wire logic        fetch_req,
    input wire logic        ctx_req,
    input wire logic        pc_load,
    input wire logic [3:0]  reg_num,
    input wire logic [15:0] ctx_new_base,
    input wire logic        reg_busy,
    input wire logic        reg_done_r,
    input wire logic        fetch_done_r,
    input wire logic        ctx_done_r,
    input wire logic [15:0] base_ptr_r,
    input wire logic [15:0] pc_r,
    input wire logic        mem_req_r,
    input wire logic        mem_we_r,
    input wire logic [14:0] mem_waddr_r,
    input wire logic [15:0] mem_wdata_r,
    input wire logic        mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_hold; mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_waddr_r)
        && $stable(mem_we_r) && $stable(mem_wdata_r); endproperty
    a_hold: assert property (p_hold) else $error("memory request changed before ack");
    property p_busy; mem_req_r |-> reg_busy; endproperty
    a_busy: assert property (p_busy) else $error("memory cycle outside busy");
    property p_rdone; reg_done_r |-> $past(mem_ack) ##1 !reg_done_r; endproperty
    a_rdone: assert property (p_rdone) else $error("access done not after ack");
    property p_radr; reg_req && !ctx_req && !reg_busy |=> mem_req_r
        && mem_waddr_r == base_ptr_r[15:1] + {11'h000, $past(reg_num)}; endproperty
    a_radr: assert property (p_radr) else $error("register word address wrong");
    property p_cfirst; ctx_req && !reg_busy |=> mem_req_r && mem_we_r
        && mem_waddr_r == $past(ctx_new_base[15:1]) + 15'h000d
        && mem_wdata_r == $past(base_ptr_r); endproperty
    a_cfirst: assert property (p_cfirst) else $error("old base not stored first");
    property p_clast; ctx_done_r |-> $past(mem_we_r) && $past(mem_ack)
        && $past(mem_waddr_r) == base_ptr_r[15:1] + 15'h000f; endproperty
    a_clast: assert property (p_clast) else $error("switch done not after third store");
    property p_fadr; fetch_req && !reg_req && !ctx_req && !pc_load && !reg_busy |=>
        mem_req_r && !mem_we_r && mem_waddr_r == pc_r[15:1]; endproperty
    a_fadr: assert property (p_fadr) else $error("fetch address not program counter");
    property p_finc; fetch_done_r |-> pc_r == $past(pc_r) + 16'h0002; endproperty
    a_finc: assert property (p_finc) else $error("program counter not advanced");
endmodule // wrc_checker
bind wrc_context wrc_checker i_chk (.clk(clk), .rstn(rstn), .reg_req(reg_req),
    .fetch_req(fetch_req), .ctx_req(ctx_req), .pc_load(pc_load), .reg_num(reg_num),
    .ctx_new_base(ctx_new_base), .reg_busy(reg_busy), .reg_done_r(reg_done_r),
    .fetch_done_r(fetch_done_r), .ctx_done_r(ctx_done_r), .base_ptr_r(base_ptr_r),
    .pc_r(pc_r), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r), .mem_waddr_r(mem_waddr_r),
    .mem_wdata_r(mem_wdata_r), .mem_ack(mem_ack));

// ===== tb/wrc_mem_model.sv
// word-wide external memory answering with a selectable delay
module wrc_mem_model (
    input  wire logic        clk,
    input  wire logic [1:0]  dly,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [14:0] waddr,
    input  wire logic [15:0] wdata,
    output logic             ack,
    output wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:32767];
    logic [1:0]  cnt = 2'h0;
    initial ack = 1'b0;
    // data only valid with ack; otherwise inverted so stale reads show up
    assign rdata = ack ? mem[waddr] : ~mem[waddr];
    always @(posedge clk) begin
        ack <= 1'b0;
        if (req && !ack) begin
            if (cnt == dly) begin
                ack <= 1'b1;
                cnt <= 2'h0;
                if (we) mem[waddr] <= wdata;
            end else cnt <= cnt + 2'h1;
        end
    end
endmodule // wrc_mem_model

// ===== tb/wrc_context_tb.sv
// self-checking bench for the workspace register context block
module wrc_context_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, reg_req = 0, reg_we = 0, reg_byte = 0, reg_odd = 0;
    logic fetch_req = 0, ctx_req = 0, pc_load = 0, psw_load = 0;
    logic [3:0] reg_num = 0;
    logic [15:0] reg_wdata = 0, nb = 0, pc_ld = 0, ps_ld = 0;
    logic [1:0] dly = 0;
    wire logic busy, rdone, fdone, cdone, mreq, mwe, mack;
    wire logic [15:0] rdat, fdat, base, pc, psw, mwd, mrd;
    wire logic [14:0] madr;
    int error_cnt = 0, n_checks = 0, i;
    wrc_context i_dut (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_we(reg_we),
        .reg_byte(reg_byte), .reg_odd(reg_odd), .reg_num(reg_num), .reg_wdata(reg_wdata),
        .reg_busy(busy), .reg_done_r(rdone), .reg_rdata_r(rdat), .fetch_req(fetch_req),
        .fetch_done_r(fdone), .fetch_data_r(fdat), .ctx_req(ctx_req), .ctx_new_base(nb),
        .ctx_new_pc(~nb), .ctx_new_psw(nb + 16'h0011), .ctx_done_r(cdone), .pc_load(pc_load),
        .pc_load_val(pc_ld), .psw_load(psw_load), .psw_load_val(ps_ld), .base_ptr_r(base),
        .pc_r(pc), .processor_status_word_r(psw), .mem_req_r(mreq), .mem_we_r(mwe),
        .mem_waddr_r(madr), .mem_wdata_r(mwd), .mem_ack(mack), .mem_rdata(mrd));
    wrc_mem_model i_mem (.clk(clk), .dly(dly), .req(mreq), .we(mwe), .waddr(madr),
        .wdata(mwd), .ack(mack), .rdata(mrd));
    initial forever #25 clk = ~clk;
    task chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // k: 0 register, 1 fetch, 2 switch, 3 pc load, 4 status load
    task rq(input int k, input logic w, b, o, input logic [3:0] n, input logic [15:0] d);
        @(posedge clk);
        {psw_load, pc_load, ctx_req, fetch_req, reg_req} <= 5'h01 << k;
        {reg_we, reg_byte, reg_odd, reg_num, reg_wdata} <= {w, b, o, n, d};
        nb <= d;
        pc_ld <= d;
        ps_ld <= d;
        @(posedge clk);
        {psw_load, pc_load, ctx_req, fetch_req, reg_req} <= 5'h00;
        if (k < 3) begin
            for (i = 0; i < 40; i++) begin
                @(negedge clk);
                if (rdone | fdone | cdone) break;
            end
            chk(i < 40, 1'b1);
        end else @(negedge clk);
    endtask
    task t_ctx;
        rq(3, 0, 0, 0, 0, 16'h1234);
        rq(4, 0, 0, 0, 0, 16'h5678);
        rq(2, 0, 0, 0, 0, 16'h0100);
        chk(base, 16'h0100);
        chk(i_mem.mem[15'h008d], 16'h0000);
        chk(i_mem.mem[15'h008e], 16'h1234);
        chk(i_mem.mem[15'h008f], 16'h5678);
        chk({pc, psw}, {16'hfeff, 16'h0111});
        rq(2, 0, 0, 0, 0, 16'hffe0);
        chk(i_mem.mem[15'h7ffd], 16'h0100);
        chk(i_mem.mem[15'h7fff], 16'h0111);
    endtask
    task t_reg;
        dly <= 2'h2;
        rq(0, 1, 0, 0, 4'h3, 16'ha5c3);
        chk(i_mem.mem[15'h7ff3], 16'ha5c3);
        rq(0, 1, 1, 1, 4'h3, 16'h007e);
        rq(0, 1, 1, 0, 4'h3, 16'h0042);
        rq(0, 0, 0, 0, 4'h3, 16'h0000);
        chk(rdat, 16'h427e);
        rq(0, 0, 1, 1, 4'h3, 16'h0000);
        chk(rdat, 16'h7e00);
        rq(0, 0, 1, 0, 4'h3, 16'h0000);
        chk(rdat, 16'h4200);
    endtask
    task t_fetch;
        i_mem.mem[15'h0008] = 16'hbeef;
        i_mem.mem[15'h0009] = 16'h1c2d;
        rq(3, 0, 0, 0, 0, 16'h0011);
        rq(1, 0, 0, 0, 0, 0);
        chk(fdat, 16'hbeef);
        rq(1, 0, 0, 0, 0, 0);
        chk({fdat, pc}, {16'h1c2d, 16'h0015});
    endtask
    task finish_test;
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_ctx;
        t_reg;
        t_fetch;
        finish_test;
    end
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
endmodule // wrc_context_tb
